// ==== rtl/acc_consts.svh ====
// Constants for the conversion control block
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_CLK_MHZ 20
`define ACC_CONV_NS 1000
`define ACC_CONV_CYC ((`ACC_CONV_NS * `ACC_CLK_MHZ) / 1000)
`define ACC_ACQ_NS 400
`define ACC_ACQ_CYC ((`ACC_ACQ_NS * `ACC_CLK_MHZ + 999) / 1000)
`define ACC_RES_BITS 16
`define ACC_MSB_FLIP 16'h8000
`define ACC_ZERO_16 16'h0000
`endif

// ==== rtl/acc_pkg.sv ====
// Types for the conversion control block
package acc_pkg;
   typedef enum logic [3:0] {
      ACC_IDLE = 4'b0001,
      ACC_CONV = 4'b0010,
      ACC_ACQ = 4'b0100,
      ACC_PDN = 4'b1000
   } acc_state_t;
   typedef struct packed {
      logic serial_parallel_sel;
      logic clock_source_sel;
      logic coding_select;
      logic low_power_sel;
      logic fast_sel;
   } acc_cfg_t;
endpackage

// ==== rtl/acc_conversion_control.sv ====
// Conversion sequencing and output interface control of a 16-bit SAR converter
// Functional notes
// R01 - A read still running when the next conversion ends loses its data and pulses the read-error flag.
// R02 - The read-error check only applies with the serial port selected and the external clock source.
// R03 - Result bits 12 to 15 are always driven as outputs regardless of interface mode.
// R04 - Busy rises at conversion start and falls once the result is latched into the shift register.
// R05 - The host may use busy falling as a data ready strobe.
// R06 - The output bus is enabled only while chip select and read strobe are both low.
// R07 - Chip select gates the external serial clock; its edges are ignored while chip select is high.
// R08 - Reset high returns the block to its reset state and aborts a running conversion.
// R09 - Power-down high lets a running conversion finish, then lowers power and blocks new starts.
// R10 - A falling edge of convert start holds the sample and begins a conversion.
// R11 - In low-power mode, convert start still low at the end of acquisition starts a conversion at once.
// R12 - The on-chip reference is on while reference disable is low and off while it is high.
// R13 - The reference buffer is on while buffer disable is low and off while it is high.
// R14 - Coding select picks straight binary or twos complement output, midscale 8000 or 0000 hex.
// R15 - A conversion aborted by reset drops busy and a new start is accepted after reset release.
`timescale 1ns/1ns
`include "acc_consts.svh"
module acc_conversion_control #(
   parameter int CONV_CYC = `ACC_CONV_CYC,
   parameter int ACQ_CYC = `ACC_ACQ_CYC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic convert_start_n,
   input wire logic power_down_in,
   input wire logic reference_disable,
   input wire logic buffer_disable,
   input wire acc_pkg::acc_cfg_t cfg,
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic ext_sclk,
   input wire logic [15:0] sar_result,
   output logic busy,
   output logic sample_hold,
   output logic read_error_flag,
   output logic bus_oe_n,
   output logic [15:0] data_out,
   output logic [15:0] data_oe_n,
   output logic serial_out,
   output logic ref_enable,
   output logic buf_enable,
   output logic low_power
);
   localparam int CW = 16;
   // Two-stage synchronisers for every pin input
   logic [7:0] s1_r, s2_r;
   logic [7:0] pins;
   assign pins = {convert_start_n, power_down_in, reference_disable, buffer_disable,
                  chip_select_n, read_n, ext_sclk, 1'b0};
   // Reset to the idle pin levels: start and selects high, power-down and serial clock low,
   // so neither a false start edge nor a spurious power-down state follows reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s1_r <= 8'hbc;
         s2_r <= 8'hbc;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
      end
   end
   logic cnv_n_s;
   logic pd_s;
   logic refd_s;
   logic bufd_s;
   logic cs_n_s;
   logic rd_n_s;
   logic sclk_s;
   assign {cnv_n_s, pd_s, refd_s, bufd_s, cs_n_s, rd_n_s, sclk_s} = s2_r[7:1];

   acc_pkg::acc_state_t st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic cnv_d_r, cnv_d_nxt;
   logic sclk_d_r, sclk_d_nxt;
   logic [15:0] shreg_r, shreg_nxt;
   logic [4:0] bitcnt_r, bitcnt_nxt;
   logic reading_r, reading_nxt;
   logic busy_nxt;
   logic sh_nxt;
   logic rderr_nxt;
   logic oe_n_nxt;
   logic sout_nxt;
   logic lp_nxt;
   logic [15:0] dout_nxt, doe_n_nxt;
   // Decoded events and modes, all from synchronised or same-clock signals
   logic start_edge;
   logic sclk_rise;
   logic done;
   logic slave_mode;
   logic lp_mode;

   assign lp_mode = cfg.low_power_sel & ~cfg.fast_sel;
   assign slave_mode = cfg.serial_parallel_sel & cfg.clock_source_sel;
   assign start_edge = cnv_d_r & ~cnv_n_s; // see R10
   // Only edges seen while selected advance the shifter
   assign sclk_rise = ~sclk_d_r & sclk_s & ~cs_n_s; // see R07
   assign done = (st_r == acc_pkg::ACC_CONV) && (cnt_r == CW'(CONV_CYC - 1));

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      cnv_d_nxt = cnv_n_s;
      sclk_d_nxt = sclk_s;
      shreg_nxt = shreg_r;
      bitcnt_nxt = bitcnt_r;
      reading_nxt = reading_r;
      rderr_nxt = 1'b0;
      case (st_r)
         acc_pkg::ACC_IDLE: begin
            if (pd_s) begin
               st_nxt = acc_pkg::ACC_PDN; // see R09
            end else if (start_edge) begin
               st_nxt = acc_pkg::ACC_CONV; // see R10
               cnt_nxt = '0;
            end
         end
         acc_pkg::ACC_CONV: begin
            cnt_nxt = cnt_r + 1'b1;
            // Power-down is not looked at here so a running conversion completes
            if (done) begin
               // Coding: flip MSB of the binary result for twos complement
               shreg_nxt = cfg.coding_select ? sar_result : (sar_result ^ `ACC_MSB_FLIP); // see R14
               if (reading_r && slave_mode) begin
                  rderr_nxt = 1'b1; // see R01 see R02
               end
               reading_nxt = 1'b0;
               bitcnt_nxt = '0;
               cnt_nxt = '0;
               st_nxt = lp_mode ? acc_pkg::ACC_ACQ : acc_pkg::ACC_IDLE;
            end
         end
         acc_pkg::ACC_ACQ: begin
            cnt_nxt = cnt_r + 1'b1;
            if (pd_s) begin
               st_nxt = acc_pkg::ACC_PDN;
            end else if (start_edge) begin
               st_nxt = acc_pkg::ACC_CONV;
               cnt_nxt = '0;
            end else if (cnt_r == CW'(ACQ_CYC - 1)) begin
               cnt_nxt = '0;
               // Start held low through acquisition starts a conversion at once
               st_nxt = ~cnv_n_s ? acc_pkg::ACC_CONV : acc_pkg::ACC_IDLE; // see R11
            end
         end
         acc_pkg::ACC_PDN: begin
            if (!pd_s) begin
               st_nxt = acc_pkg::ACC_IDLE;
            end
         end
         default: begin
            st_nxt = acc_pkg::ACC_IDLE;
         end
      endcase
      // Serial shift in slave mode, MSB first
      if (slave_mode && sclk_rise && !done) begin
         reading_nxt = (bitcnt_r != 5'd15);
         bitcnt_nxt = bitcnt_r + 5'd1;
         shreg_nxt = {shreg_r[14:0], 1'b0};
         if (bitcnt_r == 5'd16) begin
            reading_nxt = 1'b0;
            bitcnt_nxt = bitcnt_r;
            shreg_nxt = shreg_r;
         end
      end
   end

   always_comb begin
      busy_nxt = (st_nxt == acc_pkg::ACC_CONV); // see R04
      sh_nxt = busy_nxt;
      lp_nxt = (st_nxt == acc_pkg::ACC_PDN);
      oe_n_nxt = ~(~cs_n_s & ~rd_n_s); // see R06
      sout_nxt = shreg_nxt[15];
      dout_nxt = shreg_nxt;
      doe_n_nxt[11:0] = {12{oe_n_nxt}};
      doe_n_nxt[15:12] = 4'h0; // see R03
      if (cfg.serial_parallel_sel) begin
         dout_nxt[11] = rderr_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         // Abort: busy drops and the next start is taken after release
         st_r <= acc_pkg::ACC_IDLE; // see R08 see R15
         cnt_r <= '0;
         cnv_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
         shreg_r <= `ACC_ZERO_16;
         bitcnt_r <= 5'h00;
         reading_r <= 1'b0;
         busy <= 1'b0;
         sample_hold <= 1'b0;
         read_error_flag <= 1'b0;
         bus_oe_n <= 1'b1;
         data_out <= `ACC_ZERO_16;
         data_oe_n <= 16'h0fff;
         serial_out <= 1'b0;
         ref_enable <= 1'b0;
         buf_enable <= 1'b0;
         low_power <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         cnv_d_r <= cnv_d_nxt;
         sclk_d_r <= sclk_d_nxt;
         shreg_r <= shreg_nxt;
         bitcnt_r <= bitcnt_nxt;
         reading_r <= reading_nxt;
         busy <= busy_nxt;
         sample_hold <= sh_nxt;
         read_error_flag <= rderr_nxt;
         bus_oe_n <= oe_n_nxt;
         data_out <= dout_nxt;
         data_oe_n <= doe_n_nxt;
         serial_out <= sout_nxt;
         ref_enable <= ~refd_s; // see R12
         buf_enable <= ~bufd_s; // see R13
         low_power <= lp_nxt;
      end
   end
endmodule

// ==== sim/acc_chk_checker.sv ====
// Assertions on the converter control ports
`timescale 1ns/1ns
module acc_chk (
   input wire logic core_clk,
   input wire logic srst,
   input wire acc_pkg::acc_cfg_t cfg,
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic busy,
   input wire logic sample_hold,
   input wire logic read_error_flag,
   input wire logic bus_oe_n,
   input wire logic [15:0] data_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_hold_follows: assert property (sample_hold == busy) else $error("hold");
   a_busy_width: assert property ($rose(busy) |-> busy[*8] ##13 $fell(busy)) else $error("busy");
   a_bus_gate: assert property (!bus_oe_n |-> !$past(chip_select_n, 3) && !$past(read_n, 3)) else $error("gate");
   a_bus_open: assert property (!$past(srst) && !$past(srst, 2) && !$past(srst, 3) && !$past(chip_select_n, 3)
      && !$past(read_n, 3) |-> !bus_oe_n)
      else $error("open");
   a_lane_dirs: assert property (data_oe_n == {4'h0, {12{bus_oe_n}}}) else $error("lanes");
   a_err_pulse: assert property (read_error_flag |=> !read_error_flag) else $error("pulse");
   a_err_slave: assert property (read_error_flag |-> cfg.serial_parallel_sel && cfg.clock_source_sel) else $error("mode");
   a_err_idle: assert property (read_error_flag |-> !busy) else $error("idle");
endmodule
bind acc_conversion_control acc_chk chk_u (.*);

// ==== sim/acc_host_model.sv ====
// Host model that starts reading the result when busy falls, unless a read frame is still running
`timescale 1ns/1ns
module acc_host (
   input wire logic core_clk,
   input wire logic busy,
   input wire logic [4:0] nclk,
   output logic chip_select_n = 1'b1,
   output logic read_n = 1'b1,
   output logic ext_sclk = 1'b0
);
   // Serial clock stands low outside a read frame
   always @(negedge busy) begin
      @(negedge core_clk);
      chip_select_n = 1'b0;
      read_n = 1'b0;
      repeat (8) @(negedge core_clk);
      repeat (nclk) begin
         ext_sclk = 1'b1;
         repeat (3) @(negedge core_clk);
         ext_sclk = 1'b0;
         repeat (3) @(negedge core_clk);
      end
      chip_select_n = 1'b1;
      read_n = 1'b1;
   end
endmodule

// ==== sim/testbench.sv ====
// Random and corner tests of the converter control
`timescale 1ns/1ns
module testbench;
   logic core_clk = 1'b0, srst = 1'b1, convert_start_n = 1'b1, power_down_in = 1'b0, part = 1'b0;
   logic reference_disable = 1'b0, buffer_disable = 1'b0, chip_select_n, read_n, ext_sclk, busy, sample_hold;
   logic read_error_flag, bus_oe_n, serial_out, ref_enable, buf_enable, low_power;
   logic [15:0] sar_result = 16'h8000, data_out, data_oe_n;
   logic [4:0] nclk = 5'h10;
   acc_pkg::acc_cfg_t cfg = 5'h00;
   int errors = 0, n_tests = 0, nerr, w, seed = 32'h4f182d4d;
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) nerr += (read_error_flag === 1'b1);
   acc_conversion_control dut_u (.*);
   acc_host host_u (.*);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] coded(input logic binary, input logic [15:0] raw);
      return binary ? raw : {~raw[15], raw[14:0]};
   endfunction
   task automatic end_of_test;
      $display("Checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Start stays low in low-power mode so acquisition can restart alone
   task automatic convert;
      @(negedge core_clk) convert_start_n = 1'b0;
      w = 0;
      while (busy !== 1'b1 && w < 9) @(negedge core_clk) w++;
      convert_start_n = ~cfg.low_power_sel;
      w = 0;
      while (busy === 1'b1 && w < 30) @(negedge core_clk) w++;
   endtask
   initial begin
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      for (int i = 0; i < 12; i++) begin
         cfg = {i > 3 && i < 8 ? 2'b11 : 2'b00, 1'($random(seed)), 2'b00};
         {reference_disable, buffer_disable} = 2'($random(seed));
         if (i > 0) sar_result = 16'($random(seed));
         nclk = i % 3 ? 5'h10 : 5'h05;
         nerr = 0;
         convert;
         repeat (6) @(negedge core_clk);
         check(16'({w[7:0], bus_oe_n, ref_enable, buf_enable}), 16'({8'h14, 1'b0, ~reference_disable, ~buffer_disable}));
         if (!cfg[4]) check(data_out, coded(cfg[2], sar_result));
         else check(16'(serial_out), 16'(coded(cfg[2], sar_result) >> 15));
         check(16'(nerr), 16'(part && cfg[3]));
         part = cfg[3] && !nclk[4];
         w = 0;
         while (chip_select_n !== 1'b1 && w < 120) @(negedge core_clk) w++;
         check(16'(w < 120), 16'h0001);
         $display("Test %0d done", i);
      end
      cfg = 5'h02;
      convert;
      w = 0;
      while (busy !== 1'b1 && w < 12) @(negedge core_clk) w++;
      check(16'(busy), 16'h0001);
      convert_start_n = 1'b1;
      cfg = 5'h00;
      repeat (30) @(negedge core_clk);
      convert_start_n = 1'b0;
      repeat (8) @(negedge core_clk);
      srst = 1'b1;
      convert_start_n = 1'b1;
      @(negedge core_clk);
      srst = 1'b0;
      check(16'(busy), 16'h0000);
      convert;
      check(16'(w), 16'h0014);
      @(negedge core_clk) convert_start_n = 1'b0;
      repeat (4) @(negedge core_clk);
      // Power-down raised mid-conversion must let it run to the end
      power_down_in = 1'b1;
      convert_start_n = 1'b1;
      w = 0;
      while (busy === 1'b1 && w < 30) @(negedge core_clk) w++;
      check(16'(w), 16'h0013);
      repeat (4) @(negedge core_clk);
      convert;
      check(16'({busy, low_power}), 16'h0001);
      $display("Corner tests done");
      end_of_test;
   end
   initial begin
      // About eight times the expected run length
      #600000;
      errors++;
      end_of_test;
   end
endmodule
